// file: rtl/blkc_params.svh
// constants of the band lock / key control block
// assumes one clock domain; included by blkc_pkg, blkc_top, blkc_chk and tb
`ifndef BLKC_PARAMS_SVH
`define BLKC_PARAMS_SVH

`define BLKC_OP_SEC_OUT   8'hb5
`define BLKC_OP_SEC_IN    8'ha2
`define BLKC_OP_SANITIZE  8'h48
`define BLKC_SA_CRYPT_ERS 5'h03

// security out methods
`define BLKC_M_SET_OWNER  5'h01
`define BLKC_M_SET_FW     5'h02
`define BLKC_M_SET_ERASE  5'h03
`define BLKC_M_SET_BCRED  5'h04
`define BLKC_M_EN_BAND    5'h05
`define BLKC_M_SET_RANGE  5'h06
`define BLKC_M_SET_LOCK   5'h07
`define BLKC_M_REKEY      5'h09
`define BLKC_M_REVERT     5'h0a
// security in methods
`define BLKC_M_GET_RAND   5'h10
`define BLKC_M_GET_DFLT   5'h11

`define BLKC_NBANDS       32
`define BLKC_BAND_ZERO    5'h00
`define BLKC_GLOBAL0      5'h01
`define BLKC_FIRST_USER   5'h02
`define BLKC_GLOBAL1      5'h0f
`define BLKC_LAST_BAND    5'h1f

// lock field bits
`define BLKC_LK_RARM      0
`define BLKC_LK_WARM      1
`define BLKC_LK_PWR       2
`define BLKC_LK_RLOCK     3
`define BLKC_LK_WLOCK     4
`define BLKC_LK_W         5

`endif

// file: rtl/blkc_pkg.sv
// types of the band lock / key control block
// assumes blkc_params.svh sits beside it
`include "blkc_params.svh"
package blkc_pkg;
    typedef logic [255:0] blkc_key_t;
    typedef logic [4:0]   blkc_band_t;
    typedef enum logic [1:0] {ST_WRAP, ST_KEYGEN, ST_IDLE} blkc_state_t;
endpackage

// file: rtl/blkc_top.sv
// band lock, key and credential control with inline media cipher
// assumes one clock, synchronous reset, commands already parsed from the link
`timescale 1ns/100ps
`default_nettype none
`include "blkc_params.svh"
module blkc_top #(
    parameter int                 LBA_W      = 32,
    parameter int                 DAT_W      = 128,
    parameter logic [31:0]        LUN0_MAX   = 32'hffff_ffff,
    parameter logic [31:0]        LUN1_MAX   = 32'hffff_ffff,
    parameter logic [255:0]       DFLT_CRED  = 256'h5a5a_0001, // arbitrary value
    parameter logic [255:0]       LABEL_CRED = 256'h3c3c_0002, // arbitrary value
    parameter logic [255:0]       RNG_SEED   = 256'h1
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                noise_i,
    input  wire logic                power_loss_i,
    input  wire logic                cmd_valid_i,
    input  wire logic [7:0]          cmd_opcode_i,
    input  wire logic [4:0]          cmd_action_i,
    input  wire blkc_pkg::blkc_band_t cmd_band_i,
    input  wire blkc_pkg::blkc_key_t cmd_cred_i,
    input  wire blkc_pkg::blkc_key_t cmd_data_i,
    input  wire logic [LBA_W-1:0]    cmd_lba_i,
    input  wire logic [LBA_W-1:0]    cmd_len_i,
    output logic                     cmd_done_o,
    output logic                     cmd_ok_o,
    output blkc_pkg::blkc_key_t      cmd_resp_o,
    output logic                     busy_o,
    input  wire logic                dat_valid_i,
    input  wire logic                dat_write_i,
    input  wire logic                dat_lun_i,
    input  wire logic [LBA_W-1:0]    dat_lba_i,
    input  wire logic [DAT_W-1:0]    dat_i,
    output logic                     dat_valid_o,
    output logic                     dat_err_o,
    output logic [DAT_W-1:0]         dat_o,
    input  wire logic                fw_valid_i,
    input  wire logic                fw_sed_i,
    input  wire logic                fw_sig_ok_i,
    input  wire logic                fw_model_ok_i,
    input  wire logic                fw_rev_ok_i,
    input  wire logic                fw_cust_ok_i,
    output logic                     fw_accept_o,
    output logic                     fw_reject_o,
    output logic                     fw_enable_o
);
    import blkc_pkg::*;

    localparam int NB = `BLKC_NBANDS;

    initial begin
        if (LBA_W < 8 || LBA_W > 32 || DAT_W > 256 || (DAT_W % LBA_W) != 0)
            $error("blkc_top: unsupported LBA_W/DAT_W");
    end

    // band 1 and band 15 are the LUN global bands
    function automatic logic is_global(input blkc_band_t b);
        return (b == `BLKC_GLOBAL0) || (b == `BLKC_GLOBAL1);
    endfunction

    // band 15 and up belong to LUN 1
    function automatic logic band_lun(input blkc_band_t b);
        return (b >= `BLKC_GLOBAL1);
    endfunction

    function automatic logic user_band(input blkc_band_t b);
        return (b >= `BLKC_FIRST_USER) && !is_global(b);
    endfunction

    blkc_state_t      state, next_state;
    blkc_band_t       gen_idx, next_gen_idx;
    blkc_band_t       gen_hi, next_gen_hi;
    logic             pend, next_pend;
    blkc_key_t        wrap, next_wrap;
    blkc_key_t        owner, next_owner;
    blkc_key_t        erase, next_erase;
    blkc_key_t        cred [NB];
    blkc_key_t        next_cred [NB];
    blkc_key_t        wkey [NB];
    blkc_key_t        next_wkey [NB];
    logic             en [NB];
    logic             next_en [NB];
    logic             sized [NB];
    logic             next_sized [NB];
    logic [LBA_W-1:0] bstart [NB];
    logic [LBA_W-1:0] next_bstart [NB];
    logic [LBA_W-1:0] bend [NB];
    logic [LBA_W-1:0] next_bend [NB];
    logic [`BLKC_LK_W-1:0] lk [NB];
    logic [`BLKC_LK_W-1:0] next_lk [NB];
    logic             next_done, next_ok, next_busy, next_fw_en;
    blkc_key_t        next_resp;
    blkc_key_t        random_number_generator, next_rng;
    logic             nz_s1, nz_s2, pl_s1, pl_s2, pl_s3;
    logic             pl_evt;
    logic             range_ok;
    logic [LBA_W:0]   r_end;
    logic [LBA_W-1:0] lun_max;

    assign pl_evt = pl_s2 & ~pl_s3;

    // random source: 256-bit lfsr stirred by the synced noise pin
    always_comb begin
        next_rng = {random_number_generator[254:0], random_number_generator[255] ^ random_number_generator[253] ^ random_number_generator[250] ^ random_number_generator[245] ^ nz_s2};
    end

    // requested band range: inside its LUN and clear of every other enabled, sized band of the same LUN
    always_comb begin
        r_end    = {1'b0, cmd_lba_i} + {1'b0, cmd_len_i} - {{LBA_W{1'b0}}, 1'b1};
        lun_max  = band_lun(cmd_band_i) ? LUN1_MAX[LBA_W-1:0] : LUN0_MAX[LBA_W-1:0];
        range_ok = (cmd_len_i != '0) && !r_end[LBA_W] && (r_end[LBA_W-1:0] <= lun_max);
        for (int j = 2; j < NB; j++) begin
            if (j[4:0] != cmd_band_i && en[j] && sized[j] && band_lun(j[4:0]) == band_lun(cmd_band_i) &&
                !(r_end[LBA_W-1:0] < bstart[j] || cmd_lba_i > bend[j]))
                range_ok = 1'b0;
        end
    end

    // command, key generation and band state
    always_comb begin
        logic own_ok;
        logic bnd_ok;
        logic ers_ok;
        own_ok = (cmd_cred_i == owner) || (cmd_cred_i == DFLT_CRED);
        bnd_ok = (cmd_cred_i == cred[cmd_band_i]) || (cmd_cred_i == erase);
        ers_ok = (cmd_cred_i == erase);
        next_state   = state;
        next_gen_idx = gen_idx;
        next_gen_hi  = gen_hi;
        next_pend    = pend;
        next_wrap    = wrap;
        next_owner   = owner;
        next_erase   = erase;
        next_fw_en   = fw_enable_o;
        next_done    = 1'b0;
        next_ok      = 1'b0;
        next_resp    = cmd_resp_o;
        for (int i = 0; i < NB; i++) begin
            next_cred[i]   = cred[i];
            next_wkey[i]   = wkey[i];
            next_en[i]     = en[i];
            next_sized[i]  = sized[i];
            next_bstart[i] = bstart[i];
            next_bend[i]   = bend[i];
            next_lk[i]     = lk[i];
        end
        case (state)
            ST_WRAP: begin
                next_wrap    = random_number_generator;
                next_gen_idx = `BLKC_BAND_ZERO;
                next_gen_hi  = `BLKC_LAST_BAND;
                next_state   = ST_KEYGEN;
            end
            ST_KEYGEN: begin
                // stored value is the wrapped key; old value is simply overwritten
                next_wkey[gen_idx] = random_number_generator;
                if (gen_idx == gen_hi) begin
                    next_state = ST_IDLE;
                    next_done  = pend;
                    next_ok    = pend;
                    next_pend  = 1'b0;
                end else begin
                    next_gen_idx = gen_idx + 5'h01;
                end
            end
            default: begin
                if (cmd_valid_i) begin
                    next_done = 1'b1;
                    if (cmd_opcode_i == `BLKC_OP_SANITIZE && cmd_action_i == `BLKC_SA_CRYPT_ERS) begin
                        next_done    = 1'b0;
                        next_pend    = 1'b1;
                        next_gen_idx = `BLKC_BAND_ZERO;
                        next_gen_hi  = `BLKC_LAST_BAND;
                        next_state   = ST_KEYGEN;
                    end else if (cmd_opcode_i == `BLKC_OP_SEC_IN) begin
                        if (cmd_action_i == `BLKC_M_GET_RAND) begin
                            next_resp = random_number_generator;
                            next_ok   = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_GET_DFLT) begin
                            next_resp = DFLT_CRED;
                            next_ok   = 1'b1;
                        end
                    end else if (cmd_opcode_i == `BLKC_OP_SEC_OUT) begin
                        if (cmd_action_i == `BLKC_M_SET_OWNER && own_ok) begin
                            next_owner = cmd_data_i;
                            next_ok    = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_SET_FW && own_ok) begin
                            next_fw_en = cmd_data_i[0];
                            next_ok    = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_SET_ERASE && ers_ok) begin
                            next_erase = cmd_data_i;
                            next_ok    = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_SET_BCRED && cmd_band_i != `BLKC_BAND_ZERO && bnd_ok) begin
                            next_cred[cmd_band_i] = cmd_data_i;
                            next_ok               = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_EN_BAND && user_band(cmd_band_i) && ers_ok) begin
                            next_en[cmd_band_i]    = cmd_data_i[0];
                            next_sized[cmd_band_i] = sized[cmd_band_i] & cmd_data_i[0];
                            next_ok                = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_SET_RANGE && user_band(cmd_band_i) && en[cmd_band_i] &&
                                     bnd_ok && range_ok) begin
                            next_bstart[cmd_band_i] = cmd_lba_i;
                            next_bend[cmd_band_i]   = r_end[LBA_W-1:0];
                            next_sized[cmd_band_i]  = 1'b1;
                            next_ok                 = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_SET_LOCK && cmd_band_i != `BLKC_BAND_ZERO && bnd_ok) begin
                            next_lk[cmd_band_i] = cmd_data_i[`BLKC_LK_W-1:0];
                            next_ok             = 1'b1;
                        end else if (cmd_action_i == `BLKC_M_REKEY && cmd_band_i != `BLKC_BAND_ZERO && bnd_ok) begin
                            next_done    = 1'b0;
                            next_pend    = 1'b1;
                            next_gen_idx = cmd_band_i;
                            next_gen_hi  = cmd_band_i;
                            next_state   = ST_KEYGEN;
                        end else if (cmd_action_i == `BLKC_M_REVERT && cmd_cred_i == LABEL_CRED) begin
                            // factory credentials, enables and locks back, every band key replaced; wrap key and band start/end kept, sizes cleared
                            next_owner = DFLT_CRED;
                            next_erase = DFLT_CRED;
                            next_fw_en = 1'b1;
                            for (int i = 0; i < NB; i++) begin
                                next_cred[i]  = DFLT_CRED;
                                next_en[i]    = 1'b0;
                                next_sized[i] = 1'b0;
                                next_lk[i]    = '0;
                            end
                            next_done    = 1'b0;
                            next_pend    = 1'b1;
                            next_gen_idx = `BLKC_BAND_ZERO;
                            next_gen_hi  = `BLKC_LAST_BAND;
                            next_state   = ST_KEYGEN;
                        end
                    end
                end
            end
        endcase
        // relock after any same-cycle lock write, so power loss wins unless that write clears the pwr or an arm bit
        for (int i = 0; i < NB; i++) begin
            if (pl_evt && next_lk[i][`BLKC_LK_PWR] && next_lk[i][`BLKC_LK_RARM] && next_lk[i][`BLKC_LK_WARM])
                next_lk[i][`BLKC_LK_WLOCK:`BLKC_LK_RLOCK] = 2'b11;
        end
        next_busy = (next_state != ST_IDLE);
    end

    // media data path: band lookup, lock check, cipher
    logic             next_dvalid, next_derr;
    logic [DAT_W-1:0] next_dat;
    always_comb begin
        blkc_band_t       sel;
        blkc_key_t        key;
        logic [DAT_W-1:0] ks;
        logic             locked;
        sel = dat_lun_i ? `BLKC_GLOBAL1 : `BLKC_GLOBAL0;
        for (int j = 2; j < NB; j++) begin
            if (en[j] && sized[j] && band_lun(j[4:0]) == dat_lun_i &&
                dat_lba_i >= bstart[j] && dat_lba_i <= bend[j])
                sel = j[4:0];
        end
        key    = wkey[sel] ^ wrap;
        ks     = key[DAT_W-1:0] ^ key[255 -: DAT_W] ^ {(DAT_W/LBA_W){dat_lba_i}};
        locked = busy_o | (dat_write_i ? lk[sel][`BLKC_LK_WLOCK] : lk[sel][`BLKC_LK_RLOCK]);
        next_dvalid = dat_valid_i;
        next_derr   = dat_valid_i & locked;
        // no path around the cipher; a locked access returns zeros
        next_dat    = locked ? '0 : (dat_i ^ ks);
    end

    // firmware image gate
    logic next_fw_acc, next_fw_rej;
    always_comb begin
        logic img_ok;
        img_ok      = fw_enable_o & fw_sed_i & fw_sig_ok_i & fw_model_ok_i & fw_rev_ok_i & fw_cust_ok_i;
        next_fw_acc = fw_valid_i & img_ok;
        next_fw_rej = fw_valid_i & ~img_ok;
    end

    // all state registered here; reset gives factory state
    always_ff @(posedge clk_i) begin
        nz_s1 <= noise_i;
        nz_s2 <= nz_s1;
        pl_s1 <= power_loss_i;
        pl_s2 <= pl_s1;
        if (rst_i) begin
            pl_s3       <= 1'b0;
            random_number_generator         <= RNG_SEED;
            state       <= ST_WRAP;
            gen_idx     <= `BLKC_BAND_ZERO;
            gen_hi      <= `BLKC_LAST_BAND;
            pend        <= 1'b0;
            wrap        <= '0;
            owner       <= DFLT_CRED;
            erase       <= DFLT_CRED;
            fw_enable_o <= 1'b1;
            cmd_done_o  <= 1'b0;
            cmd_ok_o    <= 1'b0;
            cmd_resp_o  <= '0;
            busy_o      <= 1'b1;
            dat_valid_o <= 1'b0;
            dat_err_o   <= 1'b0;
            dat_o       <= '0;
            fw_accept_o <= 1'b0;
            fw_reject_o <= 1'b0;
            for (int i = 0; i < NB; i++) begin
                cred[i]   <= DFLT_CRED;
                wkey[i]   <= '0;
                en[i]     <= 1'b0;
                sized[i]  <= 1'b0;
                bstart[i] <= '0;
                bend[i]   <= '0;
                lk[i]     <= '0;
            end
        end else begin
            pl_s3       <= pl_s2;
            random_number_generator         <= next_rng;
            state       <= next_state;
            gen_idx     <= next_gen_idx;
            gen_hi      <= next_gen_hi;
            pend        <= next_pend;
            wrap        <= next_wrap;
            owner       <= next_owner;
            erase       <= next_erase;
            fw_enable_o <= next_fw_en;
            cmd_done_o  <= next_done;
            cmd_ok_o    <= next_ok;
            cmd_resp_o  <= next_resp;
            busy_o      <= next_busy;
            dat_valid_o <= next_dvalid;
            dat_err_o   <= next_derr;
            dat_o       <= next_dat;
            fw_accept_o <= next_fw_acc;
            fw_reject_o <= next_fw_rej;
            for (int i = 0; i < NB; i++) begin
                cred[i]   <= next_cred[i];
                wkey[i]   <= next_wkey[i];
                en[i]     <= next_en[i];
                sized[i]  <= next_sized[i];
                bstart[i] <= next_bstart[i];
                bend[i]   <= next_bend[i];
                lk[i]     <= next_lk[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/blkc_chk.sv
// concurrent checks on the top ports of the band lock block
// assumes one clock domain, synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
`include "blkc_params.svh"
module blkc_chk #(
    parameter int LBA_W = 32,
    parameter int DAT_W = 128
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cmd_valid_i,
    input wire logic [7:0]       cmd_opcode_i,
    input wire logic [4:0]       cmd_action_i,
    input wire logic             cmd_done_o,
    input wire logic             cmd_ok_o,
    input wire logic [255:0]     cmd_resp_o,
    input wire logic             busy_o,
    input wire logic             dat_valid_i,
    input wire logic             dat_valid_o,
    input wire logic             dat_err_o,
    input wire logic [DAT_W-1:0] dat_o,
    input wire logic             fw_valid_i,
    input wire logic             fw_sed_i,
    input wire logic             fw_sig_ok_i,
    input wire logic             fw_model_ok_i,
    input wire logic             fw_rev_ok_i,
    input wire logic             fw_cust_ok_i,
    input wire logic             fw_accept_o,
    input wire logic             fw_reject_o,
    input wire logic             fw_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a command taken by the idle block
    sequence s_take(op, act);
        cmd_valid_i && !busy_o && cmd_opcode_i == op && cmd_action_i == act;
    endsequence
    // all five image checks plus the download gate
    sequence s_fw_good;
        fw_sed_i && fw_sig_ok_i && fw_model_ok_i && fw_rev_ok_i && fw_cust_ok_i && fw_enable_o;
    endsequence
    a_owner_answer: assert property (s_take(`BLKC_OP_SEC_OUT, `BLKC_M_SET_OWNER) |=> cmd_done_o)
        else $error("owner command not answered next cycle");
    a_rekey_done: assert property (s_take(`BLKC_OP_SEC_OUT, `BLKC_M_REKEY) |-> ##[1:4] cmd_done_o)
        else $error("rekey not answered in time");
    a_erase_done: assert property (s_take(`BLKC_OP_SANITIZE, `BLKC_SA_CRYPT_ERS) |-> ##[1:40] (cmd_done_o && cmd_ok_o))
        else $error("sanitize erase not completed");
    a_ok_with_done: assert property (cmd_ok_o |-> cmd_done_o && !busy_o)
        else $error("ok without done");
    a_resp_held: assert property ($changed(cmd_resp_o) |-> cmd_done_o && cmd_ok_o)
        else $error("response changed outside an answer");
    a_beat_answer: assert property (dat_valid_i |=> dat_valid_o)
        else $error("media beat not answered");
    a_refused_zero: assert property (dat_err_o |-> dat_valid_o && dat_o == '0)
        else $error("refused beat leaks data");
    a_busy_refuses: assert property (dat_valid_i && busy_o |=> dat_err_o)
        else $error("beat passed during key change");
    a_fw_answer: assert property (fw_valid_i |=> fw_accept_o != fw_reject_o)
        else $error("image not answered once");
    a_fw_gate: assert property (fw_valid_i ##1 fw_accept_o |-> $past(fw_sed_i && fw_sig_ok_i && fw_model_ok_i
        && fw_rev_ok_i && fw_cust_ok_i && fw_enable_o))
        else $error("image accepted without all checks");
    c_fw_good: cover property (s_fw_good ##0 fw_valid_i);
endmodule
bind blkc_top blkc_chk #(.LBA_W(LBA_W), .DAT_W(DAT_W)) i_blkc_chk (.clk_i, .rst_i, .cmd_valid_i, .cmd_opcode_i,
    .cmd_action_i, .cmd_done_o, .cmd_ok_o, .cmd_resp_o, .busy_o, .dat_valid_i, .dat_valid_o, .dat_err_o, .dat_o,
    .fw_valid_i, .fw_sed_i, .fw_sig_ok_i, .fw_model_ok_i, .fw_rev_ok_i, .fw_cust_ok_i, .fw_accept_o,
    .fw_reject_o, .fw_enable_o);
`default_nettype wire

// file: sim/blkc_host.sv
// host initiator model: issues parsed security and sanitize commands
// assumes design samples on rising edge; drives just after falling edge
`timescale 1ns/100ps
`default_nettype none
module blkc_host (
    input  wire logic         clk_i,
    input  wire logic         busy_i,
    input  wire logic         done_i,
    input  wire logic         ok_i,
    output logic              valid_o,
    output logic [7:0]        opcode_o,
    output logic [4:0]        action_o,
    output blkc_pkg::blkc_band_t band_o,
    output blkc_pkg::blkc_key_t  cred_o,
    output blkc_pkg::blkc_key_t  data_o,
    output logic [31:0]       lba_o,
    output logic [31:0]       len_o
);
    import blkc_pkg::*;
    // idle lines start quiet
    initial begin
        {valid_o, opcode_o, action_o, band_o, cred_o, data_o, lba_o, len_o} = '0;
    end
    // one command: wait idle, strobe one cycle, scramble cred, data and lba lines, wait answer
    task automatic run(input logic [7:0] op, input logic [4:0] act, input blkc_band_t b,
        input blkc_key_t c, input blkc_key_t d, input logic [31:0] l, input logic [31:0] n,
        output logic ok, output logic hung);
        int k;
        k = 0;
        while (busy_i !== 1'b0 && k < 200) begin
            @(negedge clk_i);
            k++;
        end
        hung = (busy_i !== 1'b0);
        valid_o = 1'b1;
        opcode_o = op;
        {action_o, band_o, cred_o, data_o} = {act, b, c, d};
        {lba_o, len_o} = {l, n};
        @(negedge clk_i);
        valid_o = 1'b0;
        {cred_o, data_o, lba_o} = {~c, ~d, ~l}; // stale values must not be reused
        while (done_i !== 1'b1 && k < 400) begin
            @(negedge clk_i);
            k++;
        end
        ok = ok_i;
        hung = hung || (done_i !== 1'b1);
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// top testbench of the band lock block with host model and checker
// assumes the checker is bound inside blkc_top
`timescale 1ns/100ps
`default_nettype none
`include "blkc_params.svh"
module tb;
    import blkc_pkg::*;
    localparam blkc_key_t DC = 256'h77a1; // arbitrary value
    localparam blkc_key_t LC = 256'h99b2; // arbitrary value
    localparam logic [7:0] SO = `BLKC_OP_SEC_OUT;
    logic clk = 0, rst = 1, noise = 0, pwr = 0, dv = 0, dw = 0, fv = 0;
    logic [4:0] ff = 0;
    logic [31:0] dl = 0, seed;
    logic [127:0] di = 0, dq, d, c, q;
    logic vo, eo, fa, fr, fe, done, ok, busy, cv, e, a, r, hung;
    logic [7:0] op;
    logic [4:0] act;
    blkc_band_t bd;
    blkc_key_t cr, cdat, resp, rnd;
    logic [31:0] cl, cn;
    int bad_count = 0, n_checks = 0;
    always #4 clk = ~clk;
    // entropy pin wanders from the fixed seed
    always @(negedge clk) noise <= $random(seed);
    blkc_host i_blkc_host (.clk_i(clk), .busy_i(busy), .done_i(done), .ok_i(ok), .valid_o(cv), .opcode_o(op),
        .action_o(act), .band_o(bd), .cred_o(cr), .data_o(cdat), .lba_o(cl), .len_o(cn));
    blkc_top #(.DFLT_CRED(DC), .LABEL_CRED(LC)) i_blkc_top (.clk_i(clk), .rst_i(rst), .noise_i(noise),
        .power_loss_i(pwr), .cmd_valid_i(cv), .cmd_opcode_i(op), .cmd_action_i(act), .cmd_band_i(bd),
        .cmd_cred_i(cr), .cmd_data_i(cdat), .cmd_lba_i(cl), .cmd_len_i(cn), .cmd_done_o(done), .cmd_ok_o(ok),
        .cmd_resp_o(resp), .busy_o(busy), .dat_valid_i(dv), .dat_write_i(dw), .dat_lun_i(1'b0), .dat_lba_i(dl),
        .dat_i(di), .dat_valid_o(vo), .dat_err_o(eo), .dat_o(dq), .fw_valid_i(fv), .fw_sed_i(ff[0]),
        .fw_sig_ok_i(ff[1]), .fw_model_ok_i(ff[2]), .fw_rev_ok_i(ff[3]), .fw_cust_ok_i(ff[4]),
        .fw_accept_o(fa), .fw_reject_o(fr), .fw_enable_o(fe));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // command through the host model, outcome compared with the expected ok
    task automatic cmd(input logic [7:0] o, input logic [4:0] m, input blkc_band_t b, input blkc_key_t k,
        input blkc_key_t x, input logic [31:0] l, input logic [31:0] n, input logic exp);
        logic got;
        i_blkc_host.run(o, m, b, k, x, l, n, got, hung);
        if (hung) begin
            bad_count++;
            give_verdict();
        end
        check(got, exp);
    endtask
    // one media beat; answer appears the cycle after it is taken
    task automatic beat(input logic w, input logic [31:0] l, input logic [127:0] x);
        @(negedge clk);
        {dv, dw, dl, di} = {1'b1, w, l, x};
        @(negedge clk);
        {q, e} = {dq, eo};
        check(vo, 1'b1);
        {dv, di} = {1'b0, ~x};
    endtask
    // image offer; the flag pattern is scrambled once the offer is answered
    task automatic fw(input logic [4:0] f, input logic exp);
        @(negedge clk);
        {fv, ff} = {1'b1, f};
        @(negedge clk);
        {fv, ff} = {1'b0, ~f};
        check({fa, fr}, {exp, ~exp});
    endtask
    initial begin
        seed = 32'hc687;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 0;
        check(fe, 1'b1);
        beat(0, 32'h0010, 128'h0);
        check({e, q}, {1'b1, 128'h0});
        cmd(8'ha2, `BLKC_M_GET_DFLT, 0, 0, 0, 0, 0, 1);
        check(resp, DC);
        cmd(SO, `BLKC_M_SET_OWNER, 0, ~DC, DC, 0, 0, 0);
        cmd(SO, `BLKC_M_SET_OWNER, 0, DC, DC, 0, 0, 1);
        cmd(SO, `BLKC_M_EN_BAND, 15, DC, 1, 0, 0, 0);
        cmd(SO, `BLKC_M_SET_RANGE, 2, DC, 0, 32'h1000, 32'h1000, 0);
        cmd(SO, `BLKC_M_EN_BAND, 2, ~DC, 1, 0, 0, 0);
        for (int b = 2; b < 4; b++) cmd(SO, `BLKC_M_EN_BAND, b, DC, 1, 0, 0, 1);
        cmd(SO, `BLKC_M_SET_RANGE, 2, DC, 0, 32'h1000, 32'h1000, 1);
        cmd(SO, `BLKC_M_SET_RANGE, 3, DC, 0, 32'h1fff, 32'h1000, 0);
        cmd(SO, `BLKC_M_SET_RANGE, 3, DC, 0, 32'h2000, 32'h1000, 1);
        cmd(SO, `BLKC_M_SET_RANGE, 0, DC, 0, 32'h4000, 32'h1000, 0);
        cmd(8'ha2, `BLKC_M_GET_RAND, 0, 0, 0, 0, 0, 1);
        rnd = resp;
        cmd(8'ha2, `BLKC_M_GET_RAND, 0, 0, 0, 0, 0, 1);
        check(resp !== rnd, 1'b1);
        d = {$random(seed), $random(seed), $random(seed), $random(seed)};
        beat(1, 32'h1800, d);
        c = q;
        check({e, c !== d}, 2'b01);
        beat(0, 32'h1800, c);
        check(q, d);
        cmd(SO, `BLKC_M_SET_LOCK, 2, DC, 256'h07, 0, 0, 1);
        @(negedge clk) pwr = 1;
        repeat (6) @(negedge clk);
        pwr = 0;
        beat(0, 32'h1800, c);
        check({e, q}, {1'b1, 128'h0});
        beat(0, 32'h0010, c);
        check(e, 1'b0);
        cmd(SO, `BLKC_M_SET_LOCK, 2, DC, 256'h07, 0, 0, 1);
        beat(0, 32'h1800, c);
        check(q, d);
        cmd(SO, `BLKC_M_REKEY, 2, DC, 0, 0, 0, 1);
        beat(0, 32'h1800, c);
        check({e, q !== d}, 2'b01);
        cmd(`BLKC_OP_SANITIZE, `BLKC_SA_CRYPT_ERS, 0, 0, 0, 0, 0, 1);
        for (int i = 0; i < 6; i++) fw(5'h1f & ~(5'h01 << i), i == 5);
        cmd(SO, `BLKC_M_SET_FW, 0, DC, 0, 0, 0, 1);
        fw(5'h1f, 1'b0);
        cmd(SO, `BLKC_M_REVERT, 0, DC, 0, 0, 0, 0);
        cmd(SO, `BLKC_M_REVERT, 0, LC, 0, 0, 0, 1);
        check(fe, 1'b1);
        cmd(SO, `BLKC_M_SET_RANGE, 2, DC, 0, 32'h1000, 32'h10, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
